// [rtl/tcs_channel.sv]
// One timer channel: control register, up-timer, compare and toggle output
//
// The APB register port was chosen for this implementation.
`default_nettype none
module tcs_channel
   import tcs_pkg::*;
(
   // Clock and control
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clkEn,
   // Debug halt acknowledge, already synchronised
   input wire logic debugHalt,
   // Register writes
   input wire logic ctrlWrite,
   input wire logic cmpWrite,
   input wire logic [31:0] wdata,
   // Readback
   output logic [31:0] ctrlRead,
   output logic [31:0] cmpRead,
   output logic [31:0] countRead,
   // Events
   output logic irq,
   output logic toggleOut
);
   // All state in one struct
   typedef struct packed {
      logic debugHaltOverride;
      logic countEnable;
      logic matchIrqEnable;
      tcs_mode_type mode;
      logic eventCountSelect;
      logic dataSnapshotEnable;
      logic [DIVIDER_WIDTH-1:0] clockDivider;
      logic [COUNT_WIDTH-1:0] count;
      logic [COUNT_WIDTH-1:0] compare;
      logic irq;
      logic toggleOut;
   } tcs_chan_state_type;
   tcs_chan_state_type state;
   tcs_chan_state_type next_state;

   logic run;
   logic tick;
   logic clearReq;
   logic match;
   logic [COUNT_WIDTH-1:0] countInc;

   // Counting allowed unless halted by the debugger
   assign run = state.countEnable && (state.debugHaltOverride || !debugHalt);
   assign clearReq = ctrlWrite && wdata[COUNTER_CLEAR_POS];
   assign countInc = state.count + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
   assign match = tick && (countInc == state.compare);

   // Divider in front of the up-timer
   tcs_prescaler #(
      .WIDTH(DIVIDER_WIDTH)
   ) u_pre (
      .core_clk(core_clk),
      .rst(rst),
      .clkEn(clkEn),
      .run(run),
      .clear(clearReq),
      .divider(state.clockDivider),
      .tick(tick)
   );

   // Next-state of control, count and events
   always_comb begin
      next_state = state;
      next_state.irq = 1'b0;
      // Count advance; reload on match except in continuous mode
      if (tick) begin
         next_state.count = countInc;
         if (match) begin
            next_state.irq = state.matchIrqEnable;
            case (state.mode)
               MODE_ONE_SHOT: begin
                  next_state.count = '0;
                  if (state.matchIrqEnable) begin
                     next_state.countEnable = 1'b0;
                  end
               end
               MODE_PERIODIC: begin
                  next_state.count = '0;
               end
               MODE_TOGGLE: begin
                  next_state.count = '0;
                  next_state.toggleOut = !state.toggleOut;
               end
               MODE_CONTINUOUS: begin
                  next_state.count = countInc;
               end
               default: begin
                  next_state.count = '0;
               end
            endcase
         end
      end
      // Software writes
      if (ctrlWrite) begin
         next_state.debugHaltOverride = wdata[DEBUG_HALT_OVERRIDE_POS];
         next_state.countEnable = wdata[COUNT_ENABLE_POS];
         next_state.matchIrqEnable = wdata[MATCH_IRQ_ENABLE_POS];
         next_state.mode = tcs_mode_type'(wdata[MODE_HI_POS:MODE_LO_POS]);
         next_state.eventCountSelect = wdata[EVENT_COUNT_SELECT_POS];
         next_state.dataSnapshotEnable = wdata[DATA_SNAPSHOT_POS];
         next_state.clockDivider = wdata[DIVIDER_HI_POS:0];
         if (wdata[COUNTER_CLEAR_POS]) begin
            next_state.count = '0;
            next_state.countEnable = 1'b0;
            next_state.toggleOut = 1'b0;
         end
      end
      if (cmpWrite) begin
         next_state.compare = wdata[COUNT_WIDTH-1:0];
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= '0;
         state.clockDivider <= CONTROL_RESET[DIVIDER_HI_POS:0];
      end else if (clkEn) begin
         state <= next_state;
      end
   end

   // Readback assembly
   always_comb begin
      ctrlRead = '0;
      ctrlRead[DEBUG_HALT_OVERRIDE_POS] = state.debugHaltOverride;
      ctrlRead[COUNT_ENABLE_POS] = state.countEnable;
      ctrlRead[MATCH_IRQ_ENABLE_POS] = state.matchIrqEnable;
      ctrlRead[MODE_HI_POS:MODE_LO_POS] = state.mode;
      ctrlRead[TIMER_ACTIVE_POS] = state.countEnable;
      ctrlRead[EVENT_COUNT_SELECT_POS] = state.eventCountSelect;
      ctrlRead[DATA_SNAPSHOT_POS] = state.dataSnapshotEnable;
      ctrlRead[DIVIDER_HI_POS:0] = state.clockDivider;
   end
   assign cmpRead = {{(32-COUNT_WIDTH){1'b0}}, state.compare};
   assign countRead = {{(32-COUNT_WIDTH){1'b0}}, state.count};
   assign irq = state.irq;
   assign toggleOut = state.toggleOut;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_halt_freeze: assert property (@(posedge core_clk) disable iff (rst)
      clkEn && !state.debugHaltOverride && debugHalt && !ctrlWrite |=> $stable(state.count))
      else $error("count moved during debug halt");
   chk_override_runs: assert property (@(posedge core_clk) disable iff (rst)
      clkEn && state.countEnable && state.debugHaltOverride && tick && !match && !ctrlWrite
      |=> state.count == $past(state.count) + 24'h000001)
      else $error("count did not advance with override set");
   chk_stop_holds: assert property (@(posedge core_clk) disable iff (rst)
      clkEn && !state.countEnable && !ctrlWrite |=> $stable(state.count))
      else $error("count moved while disabled");
   chk_one_shot_off: assert property (@(posedge core_clk) disable iff (rst)
      clkEn && match && state.mode == MODE_ONE_SHOT && state.matchIrqEnable && !ctrlWrite
      |=> !state.countEnable && state.irq)
      else $error("one-shot did not stop");
   chk_irq_cause: assert property (@(posedge core_clk) disable iff (rst)
      clkEn |=> state.irq == $past(match && state.matchIrqEnable))
      else $error("interrupt without enabled match");
   chk_toggle_flip: assert property (@(posedge core_clk) disable iff (rst)
      clkEn && match && state.mode == MODE_TOGGLE && !ctrlWrite
      |=> state.toggleOut != $past(state.toggleOut) && state.count == 24'h000000)
      else $error("toggle did not flip and reload");
   chk_cont_noreload: assert property (@(posedge core_clk) disable iff (rst)
      clkEn && match && state.mode == MODE_CONTINUOUS && !ctrlWrite
      |=> state.count == $past(state.compare))
      else $error("continuous mode reloaded");
   chk_clear_all: assert property (@(posedge core_clk) disable iff (rst)
      clkEn && clearReq |=> state.count == 24'h000000 && !state.countEnable)
      else $error("clear left count or enable");
   cov_one_shot: cover property (@(posedge core_clk) match && state.mode == MODE_ONE_SHOT);
   cov_toggle: cover property (@(posedge core_clk) match && state.mode == MODE_TOGGLE);
   cov_cont: cover property (@(posedge core_clk) match && state.mode == MODE_CONTINUOUS);
endmodule : tcs_channel
`default_nettype wire

// [common/tcs_pkg.sv]
// Package with register map, field layout and constants of the timer control block
// Contract
// - Override clear: debug halt freezes the count
// - Override set: count ignores debug halt
// - Enable bit starts, clearing it stops
// - Re-enable resumes from the held count
// - One-shot clears enable on enabled interrupt
// - Enabled match of count and compare interrupts
// - Mode 00 one-shot: interrupt once, disable
// - Mode 01 periodic: interrupt every match
// - Mode 10 toggle: interrupts plus square wave
// - Mode 11 continuous: interrupt, no reload
// - Clear bit zeroes counters and enable
// - Four channel registers, reset value 0x5
// - Periodic and toggle reload on match
// - Toggle output alternates on each match
// - Continuous wraps from maximum to zero
// - Read-only active flag shows timer running
`default_nettype none
package tcs_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int NUM_CHANNELS = 4;
   localparam logic [7:0] TIMER0_CONTROL_STATUS_OFF = 8'h00;
   localparam logic [7:0] TIMER1_CONTROL_STATUS_OFF = 8'h20;
   localparam logic [7:0] TIMER2_CONTROL_STATUS_OFF = 8'h40;
   localparam logic [7:0] TIMER3_CONTROL_STATUS_OFF = 8'h60;
   localparam logic [7:0] COMPARE_VALUE_REG_OFF = 8'h04;
   localparam logic [7:0] COUNT_VALUE_REG_OFF = 8'h0C;
   localparam logic [7:0] CHANNEL_STRIDE = 8'h20;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0005;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int DEBUG_HALT_OVERRIDE_POS = 31;
   localparam int COUNT_ENABLE_POS = 30;
   localparam int MATCH_IRQ_ENABLE_POS = 29;
   localparam int MODE_HI_POS = 28;
   localparam int MODE_LO_POS = 27;
   localparam int COUNTER_CLEAR_POS = 26;
   localparam int TIMER_ACTIVE_POS = 25;
   localparam int EVENT_COUNT_SELECT_POS = 24;
   localparam int DATA_SNAPSHOT_POS = 16;
   localparam int DIVIDER_HI_POS = 7;
   localparam int COUNT_WIDTH = 24;
   localparam int DIVIDER_WIDTH = 8;
   // ---------------------------------------------------------------
   // Operating modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_ONE_SHOT = 2'b00,
      MODE_PERIODIC = 2'b01,
      MODE_TOGGLE = 2'b10,
      MODE_CONTINUOUS = 2'b11
   } tcs_mode_type;
endpackage : tcs_pkg
`default_nettype wire

// [rtl/tcs_prescaler.sv]
// Clock_divider_field divider that issues one tick per divider-plus-one enabled cycles
`default_nettype none
module tcs_prescaler
   import tcs_pkg::*;
#(
   parameter int WIDTH = DIVIDER_WIDTH
) (
   // Clock and control
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clkEn,
   // Divider control
   input wire logic run,
   input wire logic clear,
   input wire logic [WIDTH-1:0] divider,
   // Tick out
   output logic tick
);
   // All state in one struct
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } tcs_pre_state_type;
   tcs_pre_state_type state;
   tcs_pre_state_type next_state;

   // Tick when counter reaches divider
   assign tick = run && (state.cnt == divider);

   // Next-state of the divider
   always_comb begin
      next_state = state;
      if (clear) begin
         next_state.cnt = '0;
      end else if (run) begin
         if (tick) begin
            next_state.cnt = '0;
         end else begin
            next_state.cnt = state.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= '0;
      end else if (clkEn) begin
         state <= next_state;
      end
   end
endmodule : tcs_prescaler
`default_nettype wire

// [rtl/tcs_timer_top.sv]
// Four-channel timer control block with APB slave and registered outputs
`default_nettype none
module tcs_timer_top
   import tcs_pkg::*;
(
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clkEn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Debug halt acknowledge pin
   input wire logic debugHaltAck,
   // Events toward interrupt controller and pins
   output logic [NUM_CHANNELS-1:0] timerIrq,
   output logic [NUM_CHANNELS-1:0] toggleOut
);
   // All top-level state in one struct
   typedef struct packed {
      logic [1:0] haltSync;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [NUM_CHANNELS-1:0] irq;
      logic [NUM_CHANNELS-1:0] tog;
   } tcs_top_state_type;
   tcs_top_state_type state;
   tcs_top_state_type next_state;

   logic [31:0] ctrlRd [NUM_CHANNELS];
   logic [31:0] cmpRd [NUM_CHANNELS];
   logic [31:0] cntRd [NUM_CHANNELS];
   logic [NUM_CHANNELS-1:0] chIrq;
   logic [NUM_CHANNELS-1:0] chTog;
   logic [NUM_CHANNELS-1:0] ctrlWr;
   logic [NUM_CHANNELS-1:0] cmpWr;
   logic access;
   logic [1:0] chSel;
   logic [4:0] regOff;

   // Access phase takes one wait cycle; pready is registered high one cycle later
   assign access = psel && penable && !state.pready;
   assign chSel = paddr[6:5];
   assign regOff = paddr[4:0];

   // Channels, one per stride
   generate
      for (genvar i = 0; i < NUM_CHANNELS; i++) begin : g_ch
         // Addresses at or past 0x80 reach no channel
         assign ctrlWr[i] = access && pwrite && !paddr[7] && chSel == 2'(i) && regOff == 5'h00;
         assign cmpWr[i] = access && pwrite && !paddr[7] && chSel == 2'(i)
            && regOff == COMPARE_VALUE_REG_OFF[4:0];
         tcs_channel u_ch (
            .core_clk(core_clk),
            .rst(rst),
            .clkEn(clkEn),
            .debugHalt(state.haltSync[1]),
            .ctrlWrite(ctrlWr[i] && clkEn),
            .cmpWrite(cmpWr[i] && clkEn),
            .wdata(pwdata),
            .ctrlRead(ctrlRd[i]),
            .cmpRead(cmpRd[i]),
            .countRead(cntRd[i]),
            .irq(chIrq[i]),
            .toggleOut(chTog[i])
         );
      end
   endgenerate

   // Next-state: synchroniser, bus answer, output registers
   always_comb begin
      next_state = state;
      next_state.haltSync = {state.haltSync[0], debugHaltAck};
      next_state.irq = chIrq;
      next_state.tog = chTog;
      next_state.pready = access;
      next_state.pslverr = 1'b0;
      if (access && !pwrite) begin
         case (regOff)
            5'h00: next_state.prdata = ctrlRd[chSel];
            5'h04: next_state.prdata = cmpRd[chSel];
            5'h0C: next_state.prdata = cntRd[chSel];
            default: begin
               next_state.prdata = 32'h0000_0000;
               next_state.pslverr = 1'b1;
            end
         endcase
      end else if (access) begin
         next_state.pslverr = !(regOff == 5'h00 || regOff == 5'h04);
      end
      // Addresses past the last channel answer with an error and read zero
      if (paddr[7] && access) begin
         next_state.pslverr = 1'b1;
         if (!pwrite) begin
            next_state.prdata = 32'h0000_0000;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= '0;
      end else if (clkEn) begin
         state <= next_state;
      end
   end

   assign prdata = state.prdata;
   assign pready = state.pready;
   assign pslverr = state.pslverr;
   assign timerIrq = state.irq;
   assign toggleOut = state.tog;

   chk_bus_answer: assert property (@(posedge core_clk) disable iff (rst)
      clkEn && access |=> pready)
      else $error("no answer one cycle after access");
   cov_write: cover property (@(posedge core_clk) access && pwrite);
endmodule : tcs_timer_top
`default_nettype wire

// [dv/tcs_irq_sink.sv]
// Interrupt controller and toggle pin model that tallies events per channel
`default_nettype none
module tcs_irq_sink
   import tcs_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Events from the timer block
   input wire logic [NUM_CHANNELS-1:0] timerIrq,
   input wire logic [NUM_CHANNELS-1:0] toggleOut,
   // Tallies toward the bench
   output logic [NUM_CHANNELS-1:0][15:0] irqCnt,
   output logic [NUM_CHANNELS-1:0][15:0] togCnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [NUM_CHANNELS-1:0] prevToggle; // Pin level one cycle ago
   // ---------------------------------------------------------------
   // Pulse and edge tallies
   // ---------------------------------------------------------------
   // Every high cycle of an interrupt line is one taken interrupt
   always_ff @(posedge core_clk) begin
      prevToggle <= toggleOut;
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         if (rst) begin
            irqCnt[i] <= 16'h0000;
            togCnt[i] <= 16'h0000;
         end else begin
            if (timerIrq[i]) irqCnt[i] <= irqCnt[i] + 16'h0001;
            if (toggleOut[i] != prevToggle[i]) togCnt[i] <= togCnt[i] + 16'h0001;
         end
      end
   end
endmodule : tcs_irq_sink
`default_nettype wire

// [dv/tcs_timer_top_tb_top.sv]
// Self-checking bench for the four-channel timer control block
`default_nettype none
module tcs_timer_top_tb_top
   import tcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic clkEn = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic debugHaltAck = 1'b0;
   logic [NUM_CHANNELS-1:0] timerIrq;
   logic [NUM_CHANNELS-1:0] toggleOut;
   logic [NUM_CHANNELS-1:0][15:0] irqCnt;
   logic [NUM_CHANNELS-1:0][15:0] togCnt;
   int fails = 0; // Mismatch count
   int compares = 0; // Comparison count
   int cyc = 0; // Cycle stamp
   int seed = 50214; // Fixed seed
   int ch; // Drawn channel
   int cmp; // Drawn compare value
   logic [7:0] pre; // Drawn clock_divider_field
   logic [7:0] base; // Channel base address
   logic [15:0] i0; // Interrupt tally snapshot
   logic [15:0] g0; // Toggle tally snapshot
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;
   // ---------------------------------------------------------------
   // Design and partner
   // ---------------------------------------------------------------
   tcs_timer_top u_tcs_timer_top (.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .debugHaltAck(debugHaltAck), .timerIrq(timerIrq),
      .toggleOut(toggleOut));
   tcs_irq_sink u_tcs_irq_sink (.core_clk(core_clk), .rst(rst), .timerIrq(timerIrq),
      .toggleOut(toggleOut), .irqCnt(irqCnt), .togCnt(togCnt));
   // ---------------------------------------------------------------
   // Verdict, comparisons, expectations
   // ---------------------------------------------------------------
   task automatic stop_test();
      if (fails == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk32
   // Value must lie strictly above a floor
   task automatic chkGt(input logic [31:0] got, input logic [31:0] floor);
      compares++;
      if ((got > floor) !== 1'b1) begin
         fails++;
         $display("[FAIL] t=%0t got=%h floor=%h", $time, got, floor);
      end
   endtask : chkGt
   function automatic logic [31:0] ctrl(input logic ovr, en, ie, input logic [1:0] md, input logic clr,
                                         input logic [7:0] p);
      return {ovr, en, ie, md, clr, 18'h0, p};
   endfunction : ctrl
   // Readback: clear reads 0, active mirrors enable
   function automatic logic [31:0] expRd(input logic ovr, en, ie, input logic [1:0] md, input logic [7:0] p);
      return {ovr, en, ie, md, 1'b0, en, 17'h0, p};
   endfunction : expRd
   // Reload period is compare or compare plus one ticks
   function automatic logic [31:0] periodOk(input int per, input int c, input int p);
      return 32'((per == c * (p + 1)) || (per == (c + 1) * (p + 1)));
   endfunction : periodOk
   // ---------------------------------------------------------------
   // Bus and wait tasks
   // ---------------------------------------------------------------
   // Setup, access until pready, release, one idle edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fails++;
         stop_test();
      end
      @(posedge core_clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic e;
      apb(1'b0, a, 32'h0, d, e);
   endtask : rd
   // Bounded wait for the next interrupt of a channel
   task automatic waitIrq(output int t);
      logic [15:0] c0;
      int n;
      c0 = irqCnt[ch];
      n = 0;
      while (irqCnt[ch] === c0 && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      t = cyc;
      if (n >= 3000) begin
         fails++;
         stop_test();
      end
   endtask : waitIrq
   // Random channel, compare and clock_divider_field; channel cleared first
   task automatic draw();
      ch = $random(seed) & 3;
      cmp = 4 + ($random(seed) & 7);
      pre = 8'($random(seed) & 3);
      base = 8'(ch * 32);
      wr(base, ctrl(1'b0, 1'b0, 1'b0, 2'b00, 1'b1, 8'h00));
      i0 = irqCnt[ch];
      g0 = togCnt[ch];
      wr(base + COMPARE_VALUE_REG_OFF, 32'(cmp));
   endtask : draw
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] c;
      logic e;
      int t0;
      int t1;
      int t2;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      for (int k = 0; k < NUM_CHANNELS; k++) begin
         rd(8'(k * 32), a);
         chk32(a, CONTROL_RESET);
      end
      // Address past the last channel answers with an error and reads zero
      apb(1'b0, 8'h84, 32'h0, a, e);
      chk32(32'(e), 32'h1);
      chk32(a, 32'h0000_0000);
      // Refused write must not land in channel 0
      apb(1'b1, 8'h80, ctrl(1'b1, 1'b1, 1'b1, 2'b11, 1'b0, 8'hFF), a, e);
      chk32(32'(e), 32'h1);
      rd(8'h00, a);
      chk32(a, CONTROL_RESET);
      // Periodic then toggle: steady reload period, pin follows matches
      for (int m = 1; m <= 2; m++) begin
         draw();
         wr(base, ctrl(1'b0, 1'b1, 1'b1, 2'(m), 1'b0, pre));
         waitIrq(t0);
         waitIrq(t1);
         waitIrq(t2);
         chk32(t2 - t1, t1 - t0);
         chk32(periodOk(t1 - t0, cmp, int'(pre)), 32'h1);
         wr(base, ctrl(1'b0, 1'b0, 1'b1, 2'(m), 1'b0, pre));
         repeat (4) @(posedge core_clk);
         if (m == 2) chk32(32'(togCnt[ch] - g0), 32'(irqCnt[ch] - i0));
      end
      // One-shot: single interrupt, enable and active drop
      draw();
      wr(base, ctrl(1'b0, 1'b1, 1'b1, 2'b00, 1'b0, pre));
      waitIrq(t0);
      repeat (120) @(posedge core_clk);
      chk32(32'(irqCnt[ch] - i0), 32'h1);
      rd(base, a);
      chk32(a, expRd(1'b0, 1'b0, 1'b1, 2'b00, pre));
      // Continuous: interrupt on match, count runs on past compare
      draw();
      wr(base, ctrl(1'b0, 1'b1, 1'b1, 2'b11, 1'b0, pre));
      waitIrq(t0);
      repeat (8) @(posedge core_clk);
      rd(base + COUNT_VALUE_REG_OFF, a);
      chkGt(a, 32'(cmp));
      // Continuous without interrupt: stop, resume, debug halt
      draw();
      wr(base, ctrl(1'b0, 1'b1, 1'b0, 2'b11, 1'b0, 8'h00));
      rd(base, c);
      chk32(c, expRd(1'b0, 1'b1, 1'b0, 2'b11, 8'h00));
      repeat (100) @(posedge core_clk);
      wr(base, ctrl(1'b0, 1'b0, 1'b0, 2'b11, 1'b0, 8'h00));
      rd(base + COUNT_VALUE_REG_OFF, a);
      repeat (20) @(posedge core_clk);
      rd(base + COUNT_VALUE_REG_OFF, b);
      chk32(b, a);
      wr(base, ctrl(1'b0, 1'b1, 1'b0, 2'b11, 1'b0, 8'h00));
      repeat (10) @(posedge core_clk);
      rd(base + COUNT_VALUE_REG_OFF, c);
      chkGt(c, a);
      chk32(32'(irqCnt[ch] - i0), 32'h0);
      // Clock enable low freezes count; four enabled edges lie between the samples
      rd(base + COUNT_VALUE_REG_OFF, a);
      clkEn <= 1'b0;
      repeat (30) @(posedge core_clk);
      clkEn <= 1'b1;
      rd(base + COUNT_VALUE_REG_OFF, b);
      chk32(b, a + 32'h0000_0004);
      debugHaltAck <= 1'b1;
      repeat (5) @(posedge core_clk);
      rd(base + COUNT_VALUE_REG_OFF, a);
      repeat (20) @(posedge core_clk);
      rd(base + COUNT_VALUE_REG_OFF, b);
      chk32(b, a);
      wr(base, ctrl(1'b1, 1'b1, 1'b0, 2'b11, 1'b0, 8'h00));
      rd(base + COUNT_VALUE_REG_OFF, c);
      chkGt(c, b);
      debugHaltAck <= 1'b0;
      // Clear bit wins over enable and zeroes the count
      wr(base, ctrl(1'b0, 1'b1, 1'b1, 2'b11, 1'b1, pre));
      rd(base, a);
      chk32(a, expRd(1'b0, 1'b0, 1'b1, 2'b11, pre));
      rd(base + COUNT_VALUE_REG_OFF, a);
      chk32(a, 32'h0000_0000);
      stop_test();
   end
endmodule : tcs_timer_top_tb_top
`default_nettype wire
